// [verilog/pca_cascade_ac.sv]
// Purpose: Card-side handling of frames in the ready states of cascade levels 2 and 3.
// Assumes: The reader link gives frame envelope, bit clock and bit data as asynchronous pins.
// Notes: Replies go to a framer; add_crc asks it to append CRC_A to the reply.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Level-3 prefix ending 0: reply rest, 1172/fc.
// - Level-3 prefix ending 1: reply rest, 1236/fc.
// - SAK delay follows last received bit value.
// - Level-2 SAK cascade bit follows UID size.
// - Level-2 select: double active, triple ready3.
// - Level-3 prefix mismatch: mute, go halt.
// - Level-3 select wrong UID: mute, halt.
// - Level-3 select bad CRC: mute, halt.
// - Level-2 prefix match: reply rest, stay.
module pca_cascade_ac (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_frame,
    input wire logic rx_clk,
    input wire logic rx_data,
    input wire logic [31:0] uid_level2,
    input wire logic [31:0] uid_level3,
    input wire logic uid_triple,
    input wire logic enter_ready2,
    input wire logic enter_ready3,
    output pca_pkg::pca_reply_type reply,
    output pca_pkg::pca_state_type card_state
);
    pca_pkg::pca_rx_pins_type pins_async;
    pca_pkg::pca_rx_pins_type pins_sync;
    pca_pkg::pca_rx_pins_type pins_prev_reg;
    pca_pkg::pca_rx_pins_type pins_prev_next;

    assign pins_async = '{frame: rx_frame, clk: rx_clk, data: rx_data};

    pca_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    logic frame_rise;
    logic frame_fall;
    logic bit_strobe;

    assign frame_rise = pins_sync.frame & ~pins_prev_reg.frame;
    assign frame_fall = ~pins_sync.frame & pins_prev_reg.frame;
    assign bit_strobe = pins_sync.frame & pins_sync.clk & ~pins_prev_reg.clk;

    logic [63:0] buf_reg;
    logic [63:0] buf_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic last_bit_reg;
    logic last_bit_next;
    pca_pkg::pca_state_type state_reg;
    pca_pkg::pca_state_type state_next;
    logic pend_reg;
    logic pend_next;
    logic [9:0] fdt_reg;
    logic [9:0] fdt_next;
    pca_pkg::pca_reply_type hold_reg;
    pca_pkg::pca_reply_type hold_next;
    pca_pkg::pca_reply_type reply_reg;
    pca_pkg::pca_reply_type reply_next;

    logic [7:0] sel_byte;
    logic [7:0] nvb_byte;
    logic [31:0] uid_sel;
    logic [7:0] sel_expect;
    logic [7:0] bcc;
    logic [6:0] known;
    logic [31:0] mask;
    logic prefix_ok;
    logic ac_shape;
    logic crc_fb;
    logic [9:0] fdt_load;
    logic select_shape;
    logic select_ok;
    logic ac_ok;
    logic frame_judged;
    logic fire;

    always_comb begin
        sel_byte = buf_reg[7:0];
        nvb_byte = buf_reg[15:8];
        uid_sel = (state_reg == pca_pkg::ST_READY3) ? uid_level3 : uid_level2;
        sel_expect = (state_reg == pca_pkg::ST_READY3) ? pca_pkg::SEL_LEVEL3 : pca_pkg::SEL_LEVEL2;
        bcc = uid_sel[7:0] ^ uid_sel[15:8] ^ uid_sel[23:16] ^ uid_sel[31:24];
        known = 7'({nvb_byte[6:4], 3'b000} - 7'h10) + {4'h0, nvb_byte[2:0]};
        mask = (known >= pca_pkg::UID_BITS) ? 32'hFFFFFFFF : 32'((33'h1 << known) - 33'h1);
        prefix_ok = ((buf_reg[47:16] ^ uid_sel) & mask) == 32'h0;
        ac_shape = (nvb_byte[7:4] >= 4'h2) && (nvb_byte[7:4] <= 4'h6) && !nvb_byte[3]
            && (known <= pca_pkg::UID_BITS) && (cnt_reg == 7'(pca_pkg::HEADER_BITS + known));
        fdt_load = last_bit_reg ? pca_pkg::FDT_ONE_CYCLES : pca_pkg::FDT_ZERO_CYCLES;
        select_shape = (nvb_byte == pca_pkg::NVB_SELECT) && (cnt_reg == pca_pkg::SELECT_BITS);
        select_ok = (buf_reg[47:16] == uid_sel) && (buf_reg[55:48] == bcc) && (crc_reg == 16'h0000);
        ac_ok = ac_shape && prefix_ok;
        frame_judged = frame_fall && !pend_reg
            && (state_reg == pca_pkg::ST_READY2 || state_reg == pca_pkg::ST_READY3);
        fire = pend_reg && (fdt_reg <= 10'h001);
    end

    always_comb begin
        crc_fb = crc_reg[0] ^ pins_sync.data;
        pins_prev_next = pins_sync;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        crc_next = crc_reg;
        last_bit_next = last_bit_reg;

        if (frame_rise) begin
            cnt_next = 7'h00;
            crc_next = pca_pkg::CRC_INIT;
        end else if (bit_strobe) begin
            if (cnt_reg < pca_pkg::RX_MAX_BITS) begin
                buf_next[cnt_reg[5:0]] = pins_sync.data;
            end
            if (cnt_reg != 7'h7F) begin
                cnt_next = cnt_reg + 7'h01;
            end
            last_bit_next = pins_sync.data;
            crc_next = (crc_reg >> 1) ^ (crc_fb ? pca_pkg::CRC_POLY_REFL : 16'h0000);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pins_prev_reg <= '0;
            buf_reg <= '0;
            cnt_reg <= '0;
            crc_reg <= pca_pkg::CRC_INIT;
            last_bit_reg <= 1'b0;
        end else begin
            pins_prev_reg <= pins_prev_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            crc_reg <= crc_next;
            last_bit_reg <= last_bit_next;
        end
    end

    always_comb begin
        state_next = state_reg;
        pend_next = pend_reg;
        fdt_next = fdt_reg;
        hold_next = hold_reg;

        if (enter_ready2) begin
            state_next = pca_pkg::ST_READY2;
        end else if (enter_ready3) begin
            state_next = pca_pkg::ST_READY3;
        end

        if (frame_judged) begin
            state_next = pca_pkg::ST_HALT;
            if (cnt_reg >= pca_pkg::HEADER_BITS && sel_byte == sel_expect) begin
                if (select_shape) begin
                    if (select_ok) begin
                        pend_next = 1'b1;
                        fdt_next = fdt_load;
                        hold_next.add_crc = 1'b1;
                        hold_next.len = 6'h08;
                        hold_next.data = 40'h0;
                        if (state_reg == pca_pkg::ST_READY2 && uid_triple) begin
                            hold_next.data[7:0] = pca_pkg::SAK_CASCADE;
                            state_next = pca_pkg::ST_READY3;
                        end else begin
                            hold_next.data[7:0] = pca_pkg::SAK_COMPLETE;
                            state_next = pca_pkg::ST_ACTIVE;
                        end
                    end
                end else if (ac_ok) begin
                    pend_next = 1'b1;
                    fdt_next = fdt_load;
                    hold_next.add_crc = 1'b0;
                    hold_next.len = 6'(pca_pkg::REPLY_FULL_BITS - 6'(known));
                    hold_next.data = {bcc, uid_sel} >> known;
                    state_next = state_reg;
                end
            end
        end

        if (fire) begin
            pend_next = 1'b0;
        end else if (pend_reg) begin
            fdt_next = fdt_reg - 10'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= pca_pkg::ST_IDLE;
            pend_reg <= 1'b0;
            fdt_reg <= '0;
            hold_reg <= '0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            fdt_reg <= fdt_next;
            hold_reg <= hold_next;
        end
    end

    always_comb begin
        reply_next = reply_reg;
        reply_next.valid = 1'b0;
        if (fire) begin
            reply_next = hold_reg;
            reply_next.valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reply_reg <= '0;
        end else begin
            reply_reg <= reply_next;
        end
    end

    assign reply = reply_reg;
    assign card_state = state_reg;
endmodule : pca_cascade_ac
`default_nettype wire

// [verilog/pca_pkg.sv]
// Purpose: Shared constants and carriers for the cascade-level anticollision interpreter.
// Assumes: The reader frame arrives as data bits, least significant bit first, with parity already removed.
// Notes: Frame delay counts are derived from the carrier frequency and ref_clk rate.
package pca_pkg;

    localparam logic [7:0] SEL_LEVEL2 = 8'h95;
    localparam logic [7:0] SEL_LEVEL3 = 8'h97;
    localparam logic [7:0] NVB_SELECT = 8'h70;
    localparam logic [7:0] SAK_CASCADE = 8'h04;
    localparam logic [7:0] SAK_COMPLETE = 8'h00;
    localparam logic [15:0] CRC_INIT = 16'h6363;
    localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
    localparam logic [6:0] RX_MAX_BITS = 7'h40;
    localparam logic [6:0] SELECT_BITS = 7'h48;
    localparam logic [6:0] HEADER_BITS = 7'h10;
    localparam logic [6:0] UID_BITS = 7'h20;
    localparam logic [5:0] REPLY_FULL_BITS = 6'h28;

    localparam longint FC_HZ = 64'd13560000;
    localparam longint CLK_HZ = 64'd10000000;
    localparam longint FDT_ZERO_FC = 64'd1172;
    localparam longint FDT_ONE_FC = 64'd1236;
    localparam logic [9:0] FDT_ZERO_CYCLES = 10'((FDT_ZERO_FC * CLK_HZ + FC_HZ - 64'd1) / FC_HZ);
    localparam logic [9:0] FDT_ONE_CYCLES = 10'((FDT_ONE_FC * CLK_HZ + FC_HZ - 64'd1) / FC_HZ);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READY2 = 3'b001,
        ST_READY3 = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_HALT = 3'b100
    } pca_state_type;

    typedef struct packed {
        logic frame;
        logic clk;
        logic data;
    } pca_rx_pins_type;

    typedef struct packed {
        logic valid;
        logic add_crc;
        logic [5:0] len;
        logic [39:0] data;
    } pca_reply_type;

endpackage : pca_pkg

// [verilog/pca_sync.sv]
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module pca_sync #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : pca_sync
`default_nettype wire

// [sim/pca_reader_model.sv]
// Purpose: Reader model that sends bit frames on the link pins.
// Assumes: Link clock period of 800 ns, eight ref_clk cycles; data changes on its falling edge.
// Notes: The clock rests low between frames and the data line flips when released.
`timescale 1ns/1ps
`default_nettype none
module pca_reader_model (
    input wire logic ref_clk,
    output logic rx_frame = 1'b0,
    output logic rx_clk = 1'b0,
    output logic rx_data = 1'b0
);
    task automatic send(input logic [71:0] f, input int n);
        @(posedge ref_clk);
        rx_frame <= 1'b1;
        for (int i = 0; i < n; i++) begin
            rx_data <= f[i];
            repeat (4) @(posedge ref_clk);
            rx_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rx_clk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        rx_frame <= 1'b0;
        rx_data <= ~rx_data;
    endtask : send
endmodule : pca_reader_model
`default_nettype wire

// [sim/pca_cascade_ac_checker.sv]
// Purpose: Checks reply and state relations at the interpreter ports.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to every instance of the interpreter.
`timescale 1ns/1ps
`default_nettype none
module pca_cascade_ac_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_frame,
    input wire logic uid_triple,
    input wire pca_pkg::pca_reply_type reply,
    input wire pca_pkg::pca_state_type card_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic frame_prev_reg;
    logic [10:0] since_fall_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_prev_reg <= 1'b0;
            since_fall_reg <= 11'h7FF;
        end else begin
            frame_prev_reg <= rx_frame;
            if (frame_prev_reg && !rx_frame) begin
                since_fall_reg <= 11'h000;
            end else if (since_fall_reg != 11'h7FF) begin
                since_fall_reg <= since_fall_reg + 11'h001;
            end
        end
    end

    a_fdt_window: assert property (reply.valid |-> since_fall_reg >= 11'(pca_pkg::FDT_ZERO_CYCLES)
        && since_fall_reg <= 11'(pca_pkg::FDT_ONE_CYCLES) + 11'h008) else $error("reply outside frame delay");
    a_valid_pulse: assert property (reply.valid |=> !reply.valid) else $error("reply pulse too long");
    a_fdt_quiet: assert property ($fell(rx_frame) |-> !reply.valid [*8]) else $error("reply too early");
    a_halt_mute: assert property (card_state == pca_pkg::ST_HALT |-> !reply.valid) else $error("reply in halt");
    a_ac_stays: assert property (reply.valid && !reply.add_crc |->
        card_state inside {pca_pkg::ST_READY2, pca_pkg::ST_READY3}) else $error("ac reply left ready");
    a_ac_length: assert property (reply.valid && !reply.add_crc |->
        reply.len inside {[6'h08:6'h28]}) else $error("ac reply length");
    a_sak_length: assert property (reply.valid && reply.add_crc |-> reply.len == 6'h08 &&
        card_state inside {pca_pkg::ST_READY3, pca_pkg::ST_ACTIVE}) else $error("sak length or state");
    a_sak_cascade: assert property (reply.valid && reply.add_crc && card_state == pca_pkg::ST_READY3 |->
        uid_triple && reply.data[7:0] == pca_pkg::SAK_CASCADE) else $error("sak cascade");
    a_sak_done: assert property (reply.valid && reply.add_crc && card_state == pca_pkg::ST_ACTIVE |->
        reply.data[7:0] == pca_pkg::SAK_COMPLETE) else $error("sak complete");
endmodule : pca_cascade_ac_checker
bind pca_cascade_ac pca_cascade_ac_checker u_pca_cascade_ac_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .rx_frame(rx_frame), .uid_triple(uid_triple), .reply(reply), .card_state(card_state));
`default_nettype wire

// [sim/test_pca_cascade_ac.sv]
// Purpose: Self-checking bench for the cascade-level anticollision interpreter.
// Assumes: Reader frames come from the reader model on the link pins.
// Notes: A frame with no reply within 1000 cycles counts as ignored.
`timescale 1ns/1ps
`default_nettype none
module test_pca_cascade_ac;
    localparam logic [15:0] CMD [7] = '{16'h0026, 16'h0052, 16'h0050, 16'h50E0, 16'h11D0, 16'h00C2, 16'h0002};
    localparam int CMD_BITS [7] = '{7, 7, 16, 16, 16, 8, 8};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic uid_triple = 1'b1;
    logic enter_ready2 = 1'b0;
    logic enter_ready3 = 1'b0;
    logic [31:0] uid_level2 = 32'h1E7BC3A4;
    logic [31:0] uid_level3 = 32'h5A3C96E1;
    logic [71:0] cf;
    wire logic rx_frame;
    wire logic rx_clk;
    wire logic rx_data;
    pca_pkg::pca_reply_type reply;
    pca_pkg::pca_state_type card_state;
    int fails = 0;
    int comparisons = 0;
    always #50 ref_clk = ~ref_clk;
    pca_reader_model u_pca_reader_model (.ref_clk(ref_clk), .rx_frame(rx_frame), .rx_clk(rx_clk),
        .rx_data(rx_data));
    pca_cascade_ac u_pca_cascade_ac (.ref_clk(ref_clk), .rst_n(rst_n), .rx_frame(rx_frame), .rx_clk(rx_clk),
        .rx_data(rx_data), .uid_level2(uid_level2), .uid_level3(uid_level3), .uid_triple(uid_triple),
        .enter_ready2(enter_ready2), .enter_ready3(enter_ready3), .reply(reply), .card_state(card_state));
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [15:0] crc_a(input logic [71:0] d, input int n);
        logic [15:0] c;
        c = pca_pkg::CRC_INIT;
        for (int i = 0; i < n; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ pca_pkg::CRC_POLY_REFL : c >> 1;
        return c;
    endfunction : crc_a
    function automatic logic [7:0] bcc(input logic [31:0] u);
        return u[7:0] ^ u[15:8] ^ u[23:16] ^ u[31:24];
    endfunction : bcc
    task automatic enter(input logic lvl3);
        @(posedge ref_clk);
        enter_ready2 <= !lvl3;
        enter_ready3 <= lvl3;
        @(posedge ref_clk);
        enter_ready2 <= 1'b0;
        enter_ready3 <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : enter
    task automatic xfer(input logic [71:0] f, input int n, input logic [5:0] len, input logic [39:0] d,
        input logic crc, input pca_pkg::pca_state_type st);
        int t;
        int lo;
        t = 0;
        lo = f[n-1] ? int'(pca_pkg::FDT_ONE_CYCLES) : int'(pca_pkg::FDT_ZERO_CYCLES);
        u_pca_reader_model.send(f, n);
        do begin
            @(posedge ref_clk);
            #1;
            t++;
        end while (reply.valid !== 1'b1 && t < 1000);
        if (len == 6'h00) chk(t == 1000, "reply to a frame that must be ignored");
        else chk(reply.len === len && ((reply.data ^ d) & ((40'h1 << len) - 40'h1)) === 40'h0
            && reply.add_crc === crc && t >= lo && t <= lo + 6, "reply content or delay");
        chk(card_state === st, "card state");
    endtask : xfer
    task automatic ac(input logic lvl3, input int k, input logic inv);
        logic [31:0] u;
        logic [7:0] nvb;
        u = (lvl3 ? uid_level3 : uid_level2) ^ {32{inv}};
        nvb = {4'(2 + k / 8), 4'(k % 8)};
        enter(lvl3);
        xfer({40'h0, u, nvb, lvl3 ? pca_pkg::SEL_LEVEL3 : pca_pkg::SEL_LEVEL2}, 16 + k, inv ? 6'h00 : 6'(40 - k),
            40'({bcc(u), u} >> k), 1'b0, inv ? pca_pkg::ST_HALT : (lvl3 ? pca_pkg::ST_READY3 : pca_pkg::ST_READY2));
    endtask : ac
    task automatic sel(input logic lvl3, input logic [31:0] u, input logic bad, input logic [7:0] sak,
        input pca_pkg::pca_state_type st);
        logic [55:0] f;
        f = {bcc(u), u, pca_pkg::NVB_SELECT, lvl3 ? pca_pkg::SEL_LEVEL3 : pca_pkg::SEL_LEVEL2};
        enter(lvl3);
        xfer({crc_a(72'(f), 56) ^ {16{bad}}, f}, 72, st == pca_pkg::ST_HALT ? 6'h00 : 6'h08, 40'(sak), 1'b1, st);
    endtask : sel
    task automatic conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(card_state === pca_pkg::ST_IDLE && reply === '0, "reset values");
        ac(1'b1, 2, 1'b0);
        ac(1'b1, 1, 1'b0);
        ac(1'b1, 32, 1'b0);
        ac(1'b0, 13, 1'b0);
        ac(1'b1, 5, 1'b1);
        sel(1'b1, uid_level3, 1'b0, pca_pkg::SAK_COMPLETE, pca_pkg::ST_ACTIVE);
        sel(1'b1, ~uid_level3, 1'b0, 8'h00, pca_pkg::ST_HALT);
        sel(1'b1, uid_level3, 1'b1, 8'h00, pca_pkg::ST_HALT);
        sel(1'b0, uid_level2, 1'b0, pca_pkg::SAK_CASCADE, pca_pkg::ST_READY3);
        @(posedge ref_clk);
        uid_triple <= 1'b0;
        sel(1'b0, uid_level2, 1'b0, pca_pkg::SAK_COMPLETE, pca_pkg::ST_ACTIVE);
        for (int i = 0; i < 7; i++) begin
            cf = 72'(CMD[i]) | (72'(crc_a(72'(CMD[i]), CMD_BITS[i])) << CMD_BITS[i]);
            enter(i[0]);
            xfer(cf, CMD_BITS[i] + (i < 2 ? 0 : 16), 6'h00, 40'h0, 1'b0, pca_pkg::ST_HALT);
        end
        conclude();
    end
    initial begin
        #8000000;
        fails++;
        conclude();
    end
endmodule : test_pca_cascade_ac
`default_nettype wire
